// >>> verilog/wdmcc_top.sv
// watchdog mode, counter and clock control with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "wdmcc_cfg.svh"
module wdmcc_top
    import wdmcc_pkg::*;
#(
    parameter int RST_OSC_CYCLES = `WDMCC_RST_OSC_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_osc_tick,
    input wire logic i_sub_tick,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_int_reset,
    output logic o_irq,
    output logic o_run_enable
);
    initial
    begin
        if (RST_OSC_CYCLES < 1 || RST_OSC_CYCLES > 65535)
            $error("reset length out of range");
    end

    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    wdmcc_wreq_t wreq;
    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire wr_go = aw_full_q && w_full_q && !bvalid_q;

    assign o_awready = !aw_full_q && !bvalid_q;
    assign o_wready = !w_full_q && !bvalid_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign wreq = '{addr: aw_addr_q, data: w_data_q, strb: w_strb_q};

    wire wr_ctrl2 = wr_go && wreq.addr[11:2] == `WDMCC_OFS_CTRL2 >> 2 && wreq.strb[0];
    wire wr_count = wr_go && wreq.addr[11:2] == `WDMCC_OFS_COUNT >> 2 && wreq.strb[0];
    wire wr_clksel = wr_go && wreq.addr[11:2] == `WDMCC_OFS_CLKSEL >> 2 && wreq.strb[0];
    wire wr_ctrl1 = wr_go && wreq.addr[11:2] == `WDMCC_OFS_CTRL1 >> 2 && wreq.strb[0];
    wire wr_hit = wreq.addr[11:2] <= `WDMCC_OFS_CTRL1 >> 2;
    wire [7:0] wb = wreq.data[7:0];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            if (w_take)
            begin
                w_full_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (wr_go)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'h0 : 2'h3;
            end
            else if (bvalid_q && i_bready)
                bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    wdmcc_bus_state_t rd_state_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire ar_take = i_arvalid && rd_state_q == WDMCC_IDLE;
    wire rd_ctrl2 = ar_take && i_araddr[11:2] == `WDMCC_OFS_CTRL2 >> 2;

    assign o_arready = rd_state_q == WDMCC_IDLE;
    assign o_rvalid = rd_state_q == WDMCC_RESP;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    logic ovf_q;
    logic ovf_seen_q;
    logic mode_q;
    logic ie_q;
    logic [3:0] clksel_q;
    logic [7:0] count_q;
    logic run_q;
    logic tcwe_q;
    logic csrwe_q;
    logic watchdog_reset_flag_q;
    logic [15:0] rst_cnt_q;
    logic tick;

    wdmcc_tick_sel #(
        .PRE_BITS(`WDMCC_PRESCALE_BITS)
    ) u_tick (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_osc_tick(i_osc_tick),
        .i_sub_tick(i_sub_tick),
        .i_sel(clksel_q),
        .o_tick(tick)
    );

    wire in_reset = rst_cnt_q != 16'h0000;
    wire count_en = run_q && tick && !in_reset;
    wire rollover = count_en && count_q == `WDMCC_COUNT_MAX;
    wire wdt_fire = rollover && !mode_q;
    // armed by a read seeing the flag set
    wire ovf_clr = wr_ctrl2 && ovf_seen_q && !wb[`WDMCC_BIT_OVF];
    wire [7:0] ctrl2_rd = `WDMCC_CTRL2_ONES
        | {ovf_q, 1'b0, mode_q, 1'b0, ie_q, 3'b000};
    wire [7:0] ctrl1_rd = {1'b1, tcwe_q, 1'b1, csrwe_q, 1'b1, run_q, 1'b1, watchdog_reset_flag_q};

    logic [7:0] rd_byte;
    always_comb
    begin
        case (i_araddr[11:2])
            `WDMCC_OFS_CTRL2 >> 2: rd_byte = ctrl2_rd;
            `WDMCC_OFS_COUNT >> 2: rd_byte = count_q;
            `WDMCC_OFS_CLKSEL >> 2: rd_byte = `WDMCC_CLKSEL_ONES | {4'h0, clksel_q};
            `WDMCC_OFS_CTRL1 >> 2: rd_byte = ctrl1_rd;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rd_state_q <= WDMCC_IDLE;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end
        else
        begin
            case (rd_state_q)
                WDMCC_IDLE:
                begin
                    if (i_arvalid)
                    begin
                        rd_state_q <= WDMCC_RESP;
                        rdata_q <= {24'h000000, rd_byte};
                        rresp_q <= (i_araddr[11:2] <= `WDMCC_OFS_CTRL1 >> 2) ? 2'h0 : 2'h3;
                    end
                end
                WDMCC_RESP:
                begin
                    if (i_rready)
                        rd_state_q <= WDMCC_IDLE;
                end
                default: rd_state_q <= WDMCC_IDLE;
            endcase
        end
    end

    // overflow flag: set wins, watchdog reset clears
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ovf_q <= 1'b0;
            ovf_seen_q <= 1'b0;
        end
        else
        begin
            if (rollover)
                ovf_q <= 1'b1;
            else if (rst_cnt_q == 16'h0001)
                ovf_q <= 1'b0;
            else if (ovf_clr)
                ovf_q <= 1'b0;
            if (rd_ctrl2 && ovf_q)
                ovf_seen_q <= 1'b1;
            else if (ovf_clr || wr_ctrl2)
                ovf_seen_q <= 1'b0;
        end
    end

    // guarded mode and enable bits, unguarded clock select
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mode_q <= 1'b0;
            ie_q <= 1'b0;
            clksel_q <= `WDMCC_CLKSEL_RST;
        end
        else
        begin
            if (wr_ctrl2 && !wb[`WDMCC_BIT_MODE_GUARD])
                mode_q <= wb[`WDMCC_BIT_MODE];
            if (wr_ctrl2 && !wb[`WDMCC_BIT_IE_GUARD])
                ie_q <= wb[`WDMCC_BIT_IE];
            if (wr_clksel)
                clksel_q <= wb[3:0];
        end
    end

    // first control register: write enables, run, reset flag
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            tcwe_q <= 1'b0;
            csrwe_q <= 1'b0;
            run_q <= `WDMCC_RUN_RST;
            watchdog_reset_flag_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl1 && !wb[7])
                tcwe_q <= wb[6];
            if (wr_ctrl1 && !wb[5])
                csrwe_q <= wb[4];
            if (wr_ctrl1 && csrwe_q && !wb[`WDMCC_BIT_RUN_GUARD])
                run_q <= wb[`WDMCC_BIT_RUN];
            if (wdt_fire)
                watchdog_reset_flag_q <= 1'b1;
            else if (wr_ctrl1 && csrwe_q && !wb[`WDMCC_BIT_RST_GUARD])
                watchdog_reset_flag_q <= wb[`WDMCC_BIT_RST];
        end
    end

    // counter and internal reset pulse
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            count_q <= `WDMCC_COUNT_RST;
            rst_cnt_q <= 16'h0000;
        end
        else
        begin
            if (wdt_fire)
                rst_cnt_q <= 16'(RST_OSC_CYCLES);
            else if (in_reset && i_osc_tick)
                rst_cnt_q <= rst_cnt_q - 16'h0001;
            if (wr_count && tcwe_q)
                count_q <= wb;
            else if (in_reset)
                count_q <= `WDMCC_COUNT_RST;
            else if (count_en)
                count_q <= count_q + 8'h01;
        end
    end

    assign o_int_reset = in_reset;
    assign o_irq = ovf_q && mode_q && ie_q;
    assign o_run_enable = run_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ovf_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rollover |=> ovf_q) else $error("flag not set on rollover");
    a_ovf_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ovf_q && !rollover && !ovf_seen_q && rst_cnt_q != 16'h0001) |=> ovf_q)
        else $error("flag cleared without read");
    a_mode_guard: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_ctrl2 && wb[`WDMCC_BIT_MODE_GUARD]) |=> $stable(mode_q))
        else $error("mode changed with guard set");
    a_ie_guard: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_ctrl2 && wb[`WDMCC_BIT_IE_GUARD]) |=> $stable(ie_q))
        else $error("enable changed with guard set");
    a_ctrl2_ones: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rd_ctrl2 |=> (o_rdata[7:0] & `WDMCC_CTRL2_ONES) == `WDMCC_CTRL2_ONES)
        else $error("guard or reserved bit read zero");
    a_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rollover && mode_q && ie_q && !wr_ctrl2) |=> o_irq)
        else $error("interval overflow raised no irq");
    a_wdt_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wdt_fire |=> (o_int_reset && watchdog_reset_flag_q)) else $error("no watchdog reset");
    a_run_halt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!run_q && !wr_count && !in_reset) |=> $stable(count_q))
        else $error("counter ran while halted");
    a_mode_reset: assert property (@(posedge i_clk)
        i_sys_rst |=> (!mode_q && !ie_q && count_q == 8'h00))
        else $error("bad reset values");
    c_rollover: cover property (@(posedge i_clk) rollover);
    c_wdt_fire: cover property (@(posedge i_clk) wdt_fire);
    c_irq: cover property (@(posedge i_clk) o_irq);
    c_ovf_clear: cover property (@(posedge i_clk) ovf_clr);
endmodule : wdmcc_top
`default_nettype wire

// >>> verilog/wdmcc_cfg.svh
// constants for the watchdog mode and clock control block
`ifndef WDMCC_CFG_SVH
`define WDMCC_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define WDMCC_OFS_CTRL2 12'h000
`define WDMCC_OFS_COUNT 12'h004
`define WDMCC_OFS_CLKSEL 12'h008
`define WDMCC_OFS_CTRL1 12'h00C
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WDMCC_BIT_OVF 7
`define WDMCC_BIT_MODE_GUARD 6
`define WDMCC_BIT_MODE 5
`define WDMCC_BIT_IE_GUARD 4
`define WDMCC_BIT_IE 3
`define WDMCC_BIT_RUN_GUARD 3
`define WDMCC_BIT_RUN 2
`define WDMCC_BIT_RST_GUARD 1
`define WDMCC_BIT_RST 0
// ------------------------------------------------------------
// reset values, read masks and count limit
// ------------------------------------------------------------
`define WDMCC_CTRL2_ONES 8'h57
`define WDMCC_CLKSEL_ONES 8'hF0
`define WDMCC_COUNT_RST 8'h00
`define WDMCC_COUNT_MAX 8'hFF
`define WDMCC_CLKSEL_RST 4'h0
`define WDMCC_RUN_RST 1'b1
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WDMCC_RST_OSC_CYCLES 512
`define WDMCC_PRESCALE_BITS 13
`endif

// >>> verilog/wdmcc_pkg.sv
// types for the watchdog mode and clock control block
package wdmcc_pkg;
    typedef enum logic [1:0]
    {
        WDMCC_IDLE = 2'b00,
        WDMCC_RESP = 2'b01
    } wdmcc_bus_state_t;

    typedef struct packed
    {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wdmcc_wreq_t;
endpackage : wdmcc_pkg

// >>> verilog/wdmcc_tick_sel.sv
// counter input tick selection from the osc tick and prescaler taps
`timescale 1ns/100ps
`default_nettype none
module wdmcc_tick_sel
    import wdmcc_pkg::*;
#(
    parameter int PRE_BITS = 13
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_osc_tick,
    input wire logic i_sub_tick,
    input wire logic [3:0] i_sel,
    output logic o_tick
);
    initial
    begin
        if (PRE_BITS < 13)
            $error("prescaler too narrow");
    end

    logic [PRE_BITS-1:0] sys_q;
    logic [7:0] sub_q;
    logic [PRE_BITS-1:0] sys_d;
    logic [7:0] sub_d;
    logic [PRE_BITS-1:0] sys_edge;
    logic [7:0] sub_edge;

    assign sys_d = sys_q + {{(PRE_BITS-1){1'b0}}, 1'b1};
    assign sub_d = sub_q + {7'h00, i_sub_tick};
    // tap k pulses once per 2**(k+1) clocks, or once per 2**(k+1) sub ticks for the sub taps
    assign sys_edge = sys_d & ~sys_q;
    assign sub_edge = i_sub_tick ? (sub_d & ~sub_q) : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sys_q <= '0;
            sub_q <= 8'h00;
        end
        else
        begin
            sys_q <= sys_d;
            sub_q <= sub_d;
        end
    end

    always_comb
    begin
        case (i_sel)
            4'h0, 4'h1, 4'h2, 4'h3: o_tick = i_osc_tick;
            4'h4: o_tick = sub_edge[3];
            4'h5: o_tick = sub_edge[7];
            4'h8: o_tick = sys_edge[5];
            4'h9: o_tick = sys_edge[6];
            4'hA: o_tick = sys_edge[7];
            4'hB: o_tick = sys_edge[8];
            4'hC: o_tick = sys_edge[9];
            4'hD: o_tick = sys_edge[10];
            4'hE: o_tick = sys_edge[11];
            4'hF: o_tick = sys_edge[12];
            default: o_tick = 1'b0;
        endcase
    end
endmodule : wdmcc_tick_sel
`default_nettype wire

// >>> tb/wdmcc_tb.sv
// self-checking bench for the watchdog mode and clock control block
`timescale 1ns/100ps
`default_nettype none
`include "wdmcc_cfg.svh"
module testbench
    import wdmcc_pkg::*;
;
    typedef struct packed
    {
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] resp;
    } wdmcc_row_t;
    logic clk, rst, osc, sub, tick_on;
    logic [11:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, int_rst, irq, run_en;
    logic [1:0] bresp, rresp, last_b, last_r;
    logic [15:0] cyc;
    logic [31:0] d;
    int n_fail, checked, cycles, n;
    wdmcc_row_t rows[15];
    logic [3:0] codes[14];
    int divs[14];
    // ------------------------------------------------------------
    // clock, tick sources, timeout
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // osc tick every 64 cycles, sub tick every 4 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 16'h0001;
        osc <= tick_on && (cyc[5:0] == 6'h00);
        sub <= tick_on && (cyc[1:0] == 2'h0);
        cycles++;
        if (cycles == 70000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    wdmcc_top #(.RST_OSC_CYCLES(4)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_osc_tick(osc),
        .i_sub_tick(sub), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(aw_rdy),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(w_rdy),
        .o_bresp(bresp), .o_bvalid(b_vld), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(ar_rdy), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(r_vld), .i_rready(rready), .o_int_reset(int_rst), .o_irq(irq),
        .o_run_enable(run_en));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_range(input string what, input int lo, input int hi,
        input logic [31:0] got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_fail++;
            $display("unexpected %s: expected %0d to %0d, seen %h", what, lo, hi, got);
        end
    endtask : check_range
    // ready sampled at the falling edge equals its value at the next rising edge
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge clk);
            ta = awvalid & aw_rdy;
            tw = wvalid & w_rdy;
            tb = bready & b_vld;
            last_b = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge clk);
            ta = arvalid & ar_rdy;
            tr = rready & r_vld;
            v = rdata;
            last_r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask : rd
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] v;
        rd(a, v);
        check_val("register read", {24'h000000, exp}, v);
    endtask : rd_chk
    task automatic pin_chk(input string what, input logic exp, input logic got);
        @(negedge clk);
        check_val(what, {31'h0, exp}, {31'h0, got});
    endtask : pin_chk
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, tick_on, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {awaddr, araddr, wdata, cyc} = '0;
        wstrb = 4'hF;
        rows = '{{1'b0, `WDMCC_OFS_CTRL2, 8'h00, 8'h57, 2'b00},
            {1'b0, `WDMCC_OFS_COUNT, 8'h00, 8'h00, 2'b00},
            {1'b0, `WDMCC_OFS_CLKSEL, 8'h00, 8'hF0, 2'b00},
            {1'b0, `WDMCC_OFS_CTRL1, 8'h00, 8'hAE, 2'b00},
            {1'b0, 12'h010, 8'h00, 8'h00, 2'b11}, {1'b1, 12'h010, 8'h55, 8'h00, 2'b11},
            {1'b1, `WDMCC_OFS_CTRL2, 8'h60, 8'h57, 2'b00},
            {1'b1, `WDMCC_OFS_CTRL2, 8'h08, 8'h5F, 2'b00},
            {1'b1, `WDMCC_OFS_CTRL2, 8'h30, 8'h7F, 2'b00},
            {1'b1, `WDMCC_OFS_CTRL2, 8'hFF, 8'h7F, 2'b00},
            {1'b1, `WDMCC_OFS_CLKSEL, 8'hFA, 8'hFA, 2'b00},
            {1'b1, `WDMCC_OFS_CLKSEL, 8'h06, 8'hF6, 2'b00},
            {1'b1, `WDMCC_OFS_COUNT, 8'h33, 8'h00, 2'b00},
            {1'b1, `WDMCC_OFS_CTRL1, 8'h5A, 8'hFE, 2'b00},
            {1'b1, `WDMCC_OFS_COUNT, 8'h33, 8'h33, 2'b00}};
        codes = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
            4'hE, 4'hF};
        divs = '{64, 64, 64, 1024, 64, 64, 64, 128, 256, 512, 1024, 2048, 4096, 8192};
        do_reset();
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                wr(rows[i].addr, rows[i].wdata);
                check_val("write response", {30'h0, rows[i].resp}, {30'h0, last_b});
            end
            rd(rows[i].addr, d);
            check_val("read data", {24'h000000, rows[i].rdata}, d);
            check_val("read response", {30'h0, rows[i].resp}, {30'h0, last_r});
        end
        $display("test register table done");
        tick_on <= 1'b1;
        wr(`WDMCC_OFS_COUNT, 8'hFE);
        wr(`WDMCC_OFS_CLKSEL, 8'hF0);
        repeat (200) @(posedge clk);
        wr(`WDMCC_OFS_CLKSEL, 8'hF6);
        rd_chk(`WDMCC_OFS_CTRL2, 8'hFF);
        pin_chk("interrupt", 1'b1, irq);
        wr(`WDMCC_OFS_CTRL2, 8'hFF);
        wr(`WDMCC_OFS_CTRL2, 8'h7F);
        rd_chk(`WDMCC_OFS_CTRL2, 8'hFF);
        wr(`WDMCC_OFS_CTRL2, 8'h7F);
        rd_chk(`WDMCC_OFS_CTRL2, 8'h7F);
        pin_chk("interrupt", 1'b0, irq);
        wr(`WDMCC_OFS_CTRL2, 8'h47);
        rd_chk(`WDMCC_OFS_CTRL2, 8'h77);
        wr(`WDMCC_OFS_COUNT, 8'hFF);
        wr(`WDMCC_OFS_CLKSEL, 8'hF0);
        repeat (100) @(posedge clk);
        wr(`WDMCC_OFS_CLKSEL, 8'hF6);
        rd_chk(`WDMCC_OFS_CTRL2, 8'hF7);
        pin_chk("masked interrupt", 1'b0, irq);
        wr(`WDMCC_OFS_CTRL2, 8'h57);
        rd_chk(`WDMCC_OFS_CTRL2, 8'h77);
        $display("test interval overflow done");
        foreach (codes[i])
        begin
            wr(`WDMCC_OFS_CLKSEL, {4'hF, codes[i]});
            wr(`WDMCC_OFS_COUNT, 8'h00);
            repeat (3 * divs[i]) @(posedge clk);
            rd(`WDMCC_OFS_COUNT, d);
            n = (codes[i][3:1] == 3'b011) ? 0 : 2;
            check_range("count per clock code", n, n ? 4 : 0, d);
        end
        $display("test clock select done");
        wr(`WDMCC_OFS_CTRL1, 8'hA2);
        pin_chk("run enable", 1'b0, run_en);
        wr(`WDMCC_OFS_CLKSEL, 8'hF0);
        wr(`WDMCC_OFS_COUNT, 8'h05);
        repeat (200) @(posedge clk);
        rd_chk(`WDMCC_OFS_COUNT, 8'h05);
        wr(`WDMCC_OFS_CTRL1, 8'hA6);
        rd_chk(`WDMCC_OFS_CTRL1, 8'hFE);
        $display("test run enable done");
        wr(`WDMCC_OFS_CLKSEL, 8'hF6);
        wr(`WDMCC_OFS_CTRL2, 8'h17);
        rd_chk(`WDMCC_OFS_CTRL2, 8'h57);
        wr(`WDMCC_OFS_COUNT, 8'hFE);
        wr(`WDMCC_OFS_CLKSEL, 8'hF0);
        n = 0;
        while (int_rst !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check_val("internal reset", 32'h1, {31'h0, int_rst});
        n = 0;
        while (int_rst === 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        // four osc ticks at 64 cycles each, phase uncertain by one tick
        check_range("internal reset length", 192, 320, n);
        rd_chk(`WDMCC_OFS_CTRL2, 8'h57);
        rd(`WDMCC_OFS_CTRL1, d);
        check_val("watchdog reset flag", 32'h1, {31'h0, d[0]});
        wr(`WDMCC_OFS_CLKSEL, 8'hF6);
        $display("test watchdog reset done");
        // stop oscillator ticks so the count stays at zero after reset
        tick_on <= 1'b0;
        do_reset();
        rd_chk(`WDMCC_OFS_COUNT, 8'h00);
        rd_chk(`WDMCC_OFS_CLKSEL, 8'hF0);
        pin_chk("run enable", 1'b1, run_en);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
